/* rtl/ccv_pkg.sv */
package ccv_pkg;
  localparam int NUM_CH = 16;
  localparam int ADDR_W = 12;

  // Global register byte offsets
  localparam logic [11:0] TRIG_OUT_CFG_OFF = 12'h000;
  localparam logic [11:0] RUN_CTRL_OFF = 12'h004;
  localparam logic [11:0] STATUS_OFF = 12'h008;
  localparam logic [11:0] ACCEPT_FLAGS_OFF = 12'h00C;

  // Channel space: 0x200 + channel * 0x20
  localparam logic [2:0] CH_SPACE_TAG = 3'h1;
  localparam logic [4:0] MASK_LO_WOFF = 5'h00;
  localparam logic [4:0] MASK_HI_WOFF = 5'h04;
  localparam logic [4:0] CHAN_CTRL_WOFF = 5'h08;
  localparam logic [4:0] BP_DELAY_WOFF = 5'h0C;
  localparam logic [4:0] BP_LENGTH_WOFF = 5'h10;
  localparam logic [4:0] EXT_DELAY_WOFF = 5'h14;
  localparam logic [4:0] CHAN_STRETCH_WOFF = 5'h18;

  // Upper mask word fields
  localparam int HI_LEFT_MASK_HI = 15;
  localparam int HI_MULT_SEL_BIT = 16;
  localparam int HI_MULT_THR_LO = 17;
  localparam int HI_MULT_THR_HI = 21;
  localparam int HI_LOCAL_THR_LO = 22;
  localparam int HI_LOCAL_THR_HI = 24;
  localparam int HI_RIGHT_THR_LO = 25;
  localparam int HI_RIGHT_THR_HI = 27;
  localparam int HI_LEFT_THR_LO = 28;
  localparam int HI_LEFT_THR_HI = 30;
  localparam int HI_GROUP_SEL_BIT = 31;

  // Channel control and trigger output config fields
  localparam int CTRL_REQUIRE_VAL_BIT = 13;
  localparam int TOC_PROBE_EN_BIT = 15;
  localparam int TOC_CH_SEL_LO = 16;
  localparam int TOC_CH_SEL_HI = 19;
  localparam int RUN_ACTIVE_BIT = 0;

  // Reset values
  localparam logic [31:0] MASK_LO_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_HI_RST = 32'h0000_0000;
  localparam logic [31:0] CHAN_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] TRIG_OUT_CFG_RST = 32'h0000_0000;
  localparam logic [31:0] RUN_CTRL_RST = 32'h0000_0000;
endpackage : ccv_pkg

/* rtl/ccv_channel.sv */
`timescale 1ns/1ps
`default_nettype none
module ccv_channel #(
  parameter int DW = 6,
  parameter int LW = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run_clear,
  input wire logic run_active,
  input wire logic fast_trigger,
  input wire logic validation_trigger,
  input wire logic [DW-1:0] bp_delay,
  input wire logic [LW-1:0] bp_length,
  input wire logic [DW-1:0] ext_delay,
  input wire logic [LW-1:0] stretch_len,
  input wire logic require_validation,
  output logic backplane_trigger,
  output logic delayed_local_trigger,
  output logic validation_window,
  output logic pulse_accepted
);
  localparam int DEPTH = 1 << DW;

  logic [DEPTH-1:0] bp_line_q;
  logic [DEPTH-1:0] ext_line_q;
  logic bp_tap;
  logic ext_tap;
  logic bp_tap_prev_q;
  logic ext_tap_prev_q;
  logic val_prev_q;
  logic [LW-1:0] bp_cnt_q;
  logic [LW-1:0] win_cnt_q;
  logic accept_q;

  // Two independent lines: forwarded path and local processing path
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bp_line_q <= '0;
      ext_line_q <= '0;
    end else if (run_clear) begin
      bp_line_q <= '0;
      ext_line_q <= '0;
    end else begin
      bp_line_q <= {bp_line_q[DEPTH-2:0], fast_trigger};
      ext_line_q <= {ext_line_q[DEPTH-2:0], fast_trigger};
    end
  end

  assign bp_tap = (bp_delay == '0) ? fast_trigger : bp_line_q[bp_delay - 1'b1];
  assign ext_tap = (ext_delay == '0) ? fast_trigger : ext_line_q[ext_delay - 1'b1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bp_tap_prev_q <= 1'b0;
      ext_tap_prev_q <= 1'b0;
      val_prev_q <= 1'b0;
    end else begin
      bp_tap_prev_q <= bp_tap;
      ext_tap_prev_q <= ext_tap;
      val_prev_q <= validation_trigger;
    end
  end

  // Length sets how far triggers of different channels overlap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bp_cnt_q <= '0;
    end else if (run_clear) begin
      bp_cnt_q <= '0;
    end else if (bp_tap && !bp_tap_prev_q) begin
      bp_cnt_q <= bp_length;
    end else if (bp_cnt_q != '0) begin
      bp_cnt_q <= bp_cnt_q - 1'b1;
    end
  end

  // Retrigger restarts the window
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      win_cnt_q <= '0;
    end else if (run_clear) begin
      win_cnt_q <= '0;
    end else if (validation_trigger && !val_prev_q) begin
      win_cnt_q <= stretch_len;
    end else if (win_cnt_q != '0) begin
      win_cnt_q <= win_cnt_q - 1'b1;
    end
  end

  // Short delay or stretch loses one side of a pair: no compensation here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      accept_q <= 1'b0;
    end else begin
      accept_q <= ext_tap && !ext_tap_prev_q && run_active && !run_clear &&
                  (!require_validation || (win_cnt_q != '0));
    end
  end

  assign backplane_trigger = (bp_cnt_q != '0);
  assign delayed_local_trigger = ext_tap_prev_q;
  assign validation_window = (win_cnt_q != '0);
  assign pulse_accepted = accept_q;
endmodule : ccv_channel
`default_nettype wire

/* rtl/ccv_top.sv */
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Forward each fast trigger after a programmable delay, stretched to programmable length.
// - Delay local trigger by programmable external delay, separate from forwarded path.
// - Gate local and neighbour fast triggers with a 48-bit mask per channel; group triggers are not masked.
// - Mask bits: 15:0 local, 31:16 right neighbour, 47:32 left neighbour.
// - Coincidence from masked triggers by AND and summation, routed back per channel.
// - Upper bit 16 picks multiplicity when set, coincidence when clear.
// - Upper bits 21:17 are the 5-bit multiplicity threshold.
// - Three 3-bit group thresholds: bits 24:22, 27:25, 30:28.
// - Upper bit 31 picks the group or external fast trigger as source.
// - A validation trigger opens a window of the channel stretch length.
// - With control bit 13 set, accept only if delayed trigger falls in window.
// - Probes show delayed local trigger, validation window and acceptance pulses.
// - Output config bit 15 enables probes, 4-bit channel select, OR probe.
// - External delay shorter than window may lose the earlier channel.
// - Stretch shorter than window may lose the later channel.
module ccv_top #(
  parameter int DW = 6,
  parameter int LW = 8
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ccv_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [ccv_pkg::NUM_CH-1:0] local_fast_trigger,
  input wire logic [ccv_pkg::NUM_CH-1:0] right_neighbor_trigger,
  input wire logic [ccv_pkg::NUM_CH-1:0] left_neighbor_trigger,
  input wire logic [ccv_pkg::NUM_CH-1:0] group_fast_trigger,
  output logic [ccv_pkg::NUM_CH-1:0] backplane_trigger,
  output logic [ccv_pkg::NUM_CH-1:0] validation_trigger,
  output logic [ccv_pkg::NUM_CH-1:0] pulse_accepted,
  output logic probe_output_enable,
  output logic probe_delayed_local_trigger,
  output logic probe_validation_window,
  output logic probe_pulse_accepted,
  output logic probe_validation_or
);
  localparam int N = ccv_pkg::NUM_CH;

  function automatic logic [4:0] ccv_popcount16(input logic [15:0] v);
    logic [4:0] s;
    s = 5'h00;
    for (int i = 0; i < 16; i++) begin
      s = s + {4'h0, v[i]};
    end
    return s;
  endfunction : ccv_popcount16

  function automatic logic ccv_is_chan(input logic [11:0] a);
    return (a[11:9] == ccv_pkg::CH_SPACE_TAG);
  endfunction : ccv_is_chan

  function automatic logic ccv_mapped(input logic [11:0] a);
    logic ok;
    ok = 1'b0;
    if (ccv_is_chan(a)) begin
      ok = (a[4:0] <= ccv_pkg::CHAN_STRETCH_WOFF) && (a[1:0] == 2'h0);
    end else begin
      ok = (a == ccv_pkg::TRIG_OUT_CFG_OFF) || (a == ccv_pkg::RUN_CTRL_OFF) ||
           (a == ccv_pkg::STATUS_OFF) || (a == ccv_pkg::ACCEPT_FLAGS_OFF);
    end
    return ok;
  endfunction : ccv_mapped

  // Reset release through two flops
  logic rst_meta_q;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // Neighbour and group triggers arrive from other modules on pins
  logic [3*N-1:0] pin_meta_q;
  logic [3*N-1:0] pin_sync_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= {group_fast_trigger, left_neighbor_trigger, right_neighbor_trigger};
      pin_sync_q <= pin_meta_q;
    end
  end

  logic [N-1:0] right_s;
  logic [N-1:0] left_s;
  logic [N-1:0] group_s;
  assign right_s = pin_sync_q[N-1:0];
  assign left_s = pin_sync_q[2*N-1:N];
  assign group_s = pin_sync_q[3*N-1:2*N];

  // Register storage
  logic [31:0] mask_lo_q [N];
  logic [31:0] mask_hi_q [N];
  logic [31:0] chan_ctrl_q [N];
  logic [DW-1:0] bp_delay_q [N];
  logic [LW-1:0] bp_length_q [N];
  logic [DW-1:0] ext_delay_q [N];
  logic [LW-1:0] stretch_q [N];
  logic [31:0] trig_out_cfg_q;
  logic [31:0] run_ctrl_q;
  logic [N-1:0] accept_flags_q;
  logic run_prev_q;
  logic run_clear_q;

  logic wr_en;
  logic setup;
  logic [3:0] wr_ch;
  assign wr_en = psel && penable && pwrite;
  assign setup = psel && !penable;
  assign wr_ch = paddr[8:5];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < N; c++) begin
        mask_lo_q[c] <= ccv_pkg::MASK_LO_RST;
        mask_hi_q[c] <= ccv_pkg::MASK_HI_RST;
        chan_ctrl_q[c] <= ccv_pkg::CHAN_CTRL_RST;
        bp_delay_q[c] <= '0;
        bp_length_q[c] <= '0;
        ext_delay_q[c] <= '0;
        stretch_q[c] <= '0;
      end
    end else if (wr_en && ccv_is_chan(paddr)) begin
      unique case (paddr[4:0])
        ccv_pkg::MASK_LO_WOFF: mask_lo_q[wr_ch] <= pwdata;
        ccv_pkg::MASK_HI_WOFF: mask_hi_q[wr_ch] <= pwdata;
        ccv_pkg::CHAN_CTRL_WOFF: chan_ctrl_q[wr_ch] <= pwdata;
        ccv_pkg::BP_DELAY_WOFF: bp_delay_q[wr_ch] <= pwdata[DW-1:0];
        ccv_pkg::BP_LENGTH_WOFF: bp_length_q[wr_ch] <= pwdata[LW-1:0];
        ccv_pkg::EXT_DELAY_WOFF: ext_delay_q[wr_ch] <= pwdata[DW-1:0];
        ccv_pkg::CHAN_STRETCH_WOFF: stretch_q[wr_ch] <= pwdata[LW-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_out_cfg_q <= ccv_pkg::TRIG_OUT_CFG_RST;
      run_ctrl_q <= ccv_pkg::RUN_CTRL_RST;
    end else if (wr_en) begin
      if (paddr == ccv_pkg::TRIG_OUT_CFG_OFF) begin
        trig_out_cfg_q <= pwdata;
      end
      if (paddr == ccv_pkg::RUN_CTRL_OFF) begin
        run_ctrl_q <= {31'h0, pwdata[ccv_pkg::RUN_ACTIVE_BIT]};
      end
    end
  end

  logic run_active;
  assign run_active = run_ctrl_q[ccv_pkg::RUN_ACTIVE_BIT];

  // Run start is the rising edge of the run bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_prev_q <= 1'b0;
      run_clear_q <= 1'b0;
    end else begin
      run_prev_q <= run_active;
      run_clear_q <= run_active && !run_prev_q;
    end
  end

  // Channel instances
  logic [N-1:0] bp_trig;
  logic [N-1:0] dly_local;
  logic [N-1:0] win;
  logic [N-1:0] acc;
  logic [N-1:0] val_q;

  for (genvar c = 0; c < N; c++) begin : g_ch
    ccv_channel #(
      .DW(DW),
      .LW(LW)
    ) u_ch (
      .clk(ref_clk),
      .rst_n(rst_n),
      .run_clear(run_clear_q),
      .run_active(run_active),
      .fast_trigger(local_fast_trigger[c]),
      .validation_trigger(val_q[c]),
      .bp_delay(bp_delay_q[c]),
      .bp_length(bp_length_q[c]),
      .ext_delay(ext_delay_q[c]),
      .stretch_len(stretch_q[c]),
      .require_validation(chan_ctrl_q[c][ccv_pkg::CTRL_REQUIRE_VAL_BIT]),
      .backplane_trigger(bp_trig[c]),
      .delayed_local_trigger(dly_local[c]),
      .validation_window(win[c]),
      .pulse_accepted(acc[c])
    );
  end

  // Central trigger evaluation per channel
  for (genvar c = 0; c < N; c++) begin : g_eval
    logic [47:0] masked;
    logic [4:0] cnt_local;
    logic [4:0] cnt_right;
    logic [4:0] cnt_left;
    logic [6:0] mult;
    logic coinc;
    logic mult_ok;
    logic src;
    logic val_bit_q;
    assign masked = {left_s, right_s, bp_trig} &
                    {mask_hi_q[c][ccv_pkg::HI_LEFT_MASK_HI:0], mask_lo_q[c]};
    assign cnt_local = ccv_popcount16(masked[15:0]);
    assign cnt_right = ccv_popcount16(masked[31:16]);
    assign cnt_left = ccv_popcount16(masked[47:32]);
    assign mult = {2'h0, cnt_local} + {2'h0, cnt_right} + {2'h0, cnt_left};
    assign mult_ok = mult >= {2'h0, mask_hi_q[c][ccv_pkg::HI_MULT_THR_HI:ccv_pkg::HI_MULT_THR_LO]};
    assign coinc = (cnt_local >= {2'h0, mask_hi_q[c][ccv_pkg::HI_LOCAL_THR_HI:ccv_pkg::HI_LOCAL_THR_LO]}) &&
                   (cnt_right >= {2'h0, mask_hi_q[c][ccv_pkg::HI_RIGHT_THR_HI:ccv_pkg::HI_RIGHT_THR_LO]}) &&
                   (cnt_left >= {2'h0, mask_hi_q[c][ccv_pkg::HI_LEFT_THR_HI:ccv_pkg::HI_LEFT_THR_LO]});
    assign src = mask_hi_q[c][ccv_pkg::HI_GROUP_SEL_BIT] ? group_s[c] :
                 (mask_hi_q[c][ccv_pkg::HI_MULT_SEL_BIT] ? mult_ok : coinc);

    // All-zero thresholds make coincidence permanently true; window then retriggers only once
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        val_bit_q <= 1'b0;
      end else if (run_clear_q) begin
        val_bit_q <= 1'b0;
      end else begin
        val_bit_q <= src;
      end
    end
    assign val_q[c] = val_bit_q;
  end

  // Sticky acceptance flags, write one to clear, set wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      accept_flags_q <= '0;
    end else if (wr_en && (paddr == ccv_pkg::ACCEPT_FLAGS_OFF)) begin
      accept_flags_q <= (accept_flags_q & ~pwdata[N-1:0]) | acc;
    end else begin
      accept_flags_q <= accept_flags_q | acc;
    end
  end

  // Probe outputs
  logic [3:0] probe_sel;
  logic probe_en;
  logic probe_oe_q;
  logic probe_dly_q;
  logic probe_win_q;
  logic probe_acc_q;
  logic probe_or_q;
  assign probe_sel = trig_out_cfg_q[ccv_pkg::TOC_CH_SEL_HI:ccv_pkg::TOC_CH_SEL_LO];
  assign probe_en = trig_out_cfg_q[ccv_pkg::TOC_PROBE_EN_BIT];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      probe_oe_q <= 1'b0;
      probe_dly_q <= 1'b0;
      probe_win_q <= 1'b0;
      probe_acc_q <= 1'b0;
      probe_or_q <= 1'b0;
    end else begin
      probe_oe_q <= probe_en;
      probe_dly_q <= probe_en && dly_local[probe_sel];
      probe_win_q <= probe_en && win[probe_sel];
      probe_acc_q <= probe_en && acc[probe_sel];
      probe_or_q <= probe_en && (|val_q);
    end
  end

  assign probe_output_enable = probe_oe_q;
  assign probe_delayed_local_trigger = probe_dly_q;
  assign probe_validation_window = probe_win_q;
  assign probe_pulse_accepted = probe_acc_q;
  assign probe_validation_or = probe_or_q;
  assign backplane_trigger = bp_trig;
  assign validation_trigger = val_q;
  assign pulse_accepted = acc;

  // Read data captured in setup, so access completes with zero wait
  logic [31:0] rd_mux;
  logic [31:0] prdata_q;
  logic pslverr_q;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (ccv_is_chan(paddr)) begin
      unique case (paddr[4:0])
        ccv_pkg::MASK_LO_WOFF: rd_mux = mask_lo_q[wr_ch];
        ccv_pkg::MASK_HI_WOFF: rd_mux = mask_hi_q[wr_ch];
        ccv_pkg::CHAN_CTRL_WOFF: rd_mux = chan_ctrl_q[wr_ch];
        ccv_pkg::BP_DELAY_WOFF: rd_mux = {{(32-DW){1'b0}}, bp_delay_q[wr_ch]};
        ccv_pkg::BP_LENGTH_WOFF: rd_mux = {{(32-LW){1'b0}}, bp_length_q[wr_ch]};
        ccv_pkg::EXT_DELAY_WOFF: rd_mux = {{(32-DW){1'b0}}, ext_delay_q[wr_ch]};
        ccv_pkg::CHAN_STRETCH_WOFF: rd_mux = {{(32-LW){1'b0}}, stretch_q[wr_ch]};
        default: rd_mux = 32'h0000_0000;
      endcase
    end else if (paddr == ccv_pkg::TRIG_OUT_CFG_OFF) begin
      rd_mux = trig_out_cfg_q;
    end else if (paddr == ccv_pkg::RUN_CTRL_OFF) begin
      rd_mux = run_ctrl_q;
    end else if (paddr == ccv_pkg::STATUS_OFF) begin
      rd_mux = {val_q, win};
    end else if (paddr == ccv_pkg::ACCEPT_FLAGS_OFF) begin
      rd_mux = {16'h0000, accept_flags_q};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      pslverr_q <= !ccv_mapped(paddr);
    end
  end

  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign pready = 1'b1;
endmodule : ccv_top
`default_nettype wire

/* testbench/ccv_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module ccv_checker #(
  parameter int DW = 6,
  parameter int LW = 8
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ccv_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [ccv_pkg::NUM_CH-1:0] group_fast_trigger,
  input wire logic [ccv_pkg::NUM_CH-1:0] validation_trigger,
  input wire logic [ccv_pkg::NUM_CH-1:0] pulse_accepted,
  input wire logic probe_output_enable,
  input wire logic probe_delayed_local_trigger,
  input wire logic probe_validation_window,
  input wire logic probe_pulse_accepted,
  input wire logic probe_validation_or
);
  logic [1:0] up_q;
  logic [31:0] cfg_q;
  logic run_q;
  logic grp_q;
  logic live;
  logic wacc;
  assign live = (up_q == 2'h3);
  assign wacc = psel && penable && pwrite && pready;
  // Internal reset trails reset_n by two flops
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      up_q <= 2'h0;
    end else if (!live) begin
      up_q <= up_q + 2'h1;
    end
  end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q <= 32'h0;
      run_q <= 1'b0;
      grp_q <= 1'b0;
    end else if (wacc) begin
      if (paddr == 12'h000) cfg_q <= pwdata;
      if (paddr == 12'h004) run_q <= pwdata[0];
      if (paddr == 12'h244) grp_q <= pwdata[31];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_accept_single: assert property (live |-> (pulse_accepted & $past(pulse_accepted)) == 16'h0)
    else $error("acceptance pulse longer than one cycle");
  a_accept_in_run: assert property ((!run_q)[*3] |-> pulse_accepted == 16'h0)
    else $error("acceptance while run stopped");
  a_probe_gated: assert property (!probe_output_enable && !$past(probe_output_enable) |->
    !(probe_delayed_local_trigger || probe_validation_window || probe_pulse_accepted || probe_validation_or))
    else $error("probe driven while disabled");
  a_probe_enable: assert property (live |-> probe_output_enable == $past(cfg_q[15]))
    else $error("probe enable does not follow config");
  a_probe_or: assert property (live && probe_output_enable && $past(probe_output_enable) |->
    probe_validation_or == $past(|validation_trigger))
    else $error("validation OR probe wrong");
  a_probe_accept: assert property (live && probe_pulse_accepted |-> $past(pulse_accepted) != 16'h0)
    else $error("probe acceptance without acceptance");
  a_group_source: assert property ((live && grp_q && group_fast_trigger[2])[*4] |-> validation_trigger[2])
    else $error("group trigger not selected");
  a_cfg_readback: assert property (psel && penable && !pwrite && paddr == 12'h000 |-> prdata == cfg_q)
    else $error("output config readback wrong");
  a_unmapped_error: assert property (psel && penable && paddr == 12'h21C |-> pslverr)
    else $error("unmapped access without error");
  a_status_quiet: assert property (psel && penable && paddr == 12'h008 |-> !pslverr)
    else $error("status access flagged as error");
endmodule : ccv_checker
bind ccv_top ccv_checker #(.DW(DW), .LW(LW)) chk_u (
  .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .group_fast_trigger(group_fast_trigger),
  .validation_trigger(validation_trigger), .pulse_accepted(pulse_accepted),
  .probe_output_enable(probe_output_enable), .probe_delayed_local_trigger(probe_delayed_local_trigger),
  .probe_validation_window(probe_validation_window), .probe_pulse_accepted(probe_pulse_accepted),
  .probe_validation_or(probe_validation_or)
);
`default_nettype wire

/* testbench/ccv_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Neighbour modules and group source: one commanded pulse at a time
module ccv_far_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] fire,
  input wire logic [3:0] ch,
  input wire logic [7:0] hold,
  output logic [15:0] right_trig,
  output logic [15:0] left_trig,
  output logic [15:0] group_trig
);
  logic [2:0] sel_q;
  logic [7:0] cnt_q;
  logic [2:0] on;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= 3'h0;
      cnt_q <= 8'h0;
    end else if (fire != 3'h0) begin
      sel_q <= fire;
      cnt_q <= hold - 8'h1;
    end else if (cnt_q != 8'h0) begin
      cnt_q <= cnt_q - 8'h1;
    end
  end
  // Pins idle low; a pulse starts in the commanded cycle
  assign on = fire | ((cnt_q != 8'h0) ? sel_q : 3'h0);
  assign right_trig = on[0] ? (16'h1 << ch) : 16'h0;
  assign left_trig = on[1] ? (16'h1 << ch) : 16'h0;
  assign group_trig = on[2] ? (16'h1 << ch) : 16'h0;
endmodule : ccv_far_model
`default_nettype wire

/* testbench/ccv_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module ccv_top_tb;
  logic ref_clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] lft, right_t, left_t, group_t, bp_t;
  logic poe, pdl, pvw, ppa, pvo;
  logic [2:0] far_fire;
  logic [3:0] far_ch;
  int fail_count = 0, tests_run = 0, cyc = 0, pa_cnt, pd_cnt, pw_cnt, pv_cnt, bp_cnt;
  ccv_top #(.DW(6), .LW(8)) dut_u (
    .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .local_fast_trigger(lft),
    .right_neighbor_trigger(right_t), .left_neighbor_trigger(left_t), .group_fast_trigger(group_t),
    .backplane_trigger(bp_t), .validation_trigger(), .pulse_accepted(), .probe_output_enable(poe),
    .probe_delayed_local_trigger(pdl), .probe_validation_window(pvw), .probe_pulse_accepted(ppa),
    .probe_validation_or(pvo)
  );
  ccv_far_model far_u (.clk(ref_clk), .rst_n(reset_n), .fire(far_fire), .ch(far_ch), .hold(8'h8),
    .right_trig(right_t), .left_trig(left_t), .group_trig(group_t));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  // Run is about 1000 cycles; ceiling leaves margin
  always @(posedge ref_clk) begin
    cyc++;
    if (ppa === 1'b1) pa_cnt++;
    if (pdl === 1'b1) pd_cnt++;
    if (pvw === 1'b1) pw_cnt++;
    if (pvo === 1'b1) pv_cnt++;
    if (bp_t[2] === 1'b1) bp_cnt++;
    if (cyc == 6000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask : wr
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    `CHK(rd, exp)
    `CHK(err, experr)
  endtask : rdchk
  // Channels 2 and 3 share one setup; backplane delay 0, length 8
  task automatic cfg(input logic [31:0] lo, input logic [31:0] hi, input logic req, input logic [31:0] ext,
                     input logic [31:0] st);
    logic [11:0] b;
    for (int c = 2; c < 4; c++) begin
      b = 12'h200 + 12'(c * 32);
      wr(b, lo);
      wr(b + 12'h4, hi);
      wr(b + 12'h8, req ? 32'h2000 : 32'h0);
      wr(b + 12'hC, 32'h0);
      wr(b + 12'h10, 32'h8);
      wr(b + 12'h14, ext);
      wr(b + 12'h18, st);
    end
  endtask : cfg
  // Fresh run, channel 2 fires, channel 3 k cycles later if k > 0
  task automatic pair(input int k, input logic [2:0] far, input logic [31:0] exp);
    wr(12'h004, 32'h0);
    wr(12'h004, 32'h1);
    wr(12'h00C, 32'hFFFF);
    lft <= 16'h4;
    far_fire <= far;
    @(posedge ref_clk);
    far_fire <= 3'h0;
    if (k > 1) repeat (k - 1) @(posedge ref_clk);
    if (k > 0) lft <= 16'hC;
    repeat (2) @(posedge ref_clk);
    lft <= 16'h0;
    repeat (30) @(posedge ref_clk);
    rdchk(12'h00C, exp, 1'b0);
  endtask : pair
  task automatic t_regs();
    rdchk(12'h000, 32'h0, 1'b0);
    wr(12'h2A4, 32'hA5A5_5A5A);
    rdchk(12'h2A4, 32'hA5A5_5A5A, 1'b0);
    rdchk(12'h21C, 32'h0, 1'b1);
    wr(12'h008, 32'hFFFF_FFFF);
    // Zero thresholds always validate; channel 5 now waits on its idle group pin
    rdchk(12'h008, 32'hFFDF_0000, 1'b0);
  endtask : t_regs
  task automatic t_coinc();
    cfg(32'hFFFF, 32'h0080_0000, 1'b1, 32'h8, 32'h8);
    bp_cnt = 0;
    pair(4, 3'h0, 32'hC);
    `CHK(bp_cnt, 8)
    cfg(32'h4, 32'h0080_0000, 1'b1, 32'h8, 32'h8);
    pair(4, 3'h0, 32'h0);
  endtask : t_coinc
  task automatic t_windows();
    cfg(32'hFFFF, 32'h0080_0000, 1'b1, 32'h5, 32'h8);
    pair(4, 3'h0, 32'h8);
    cfg(32'hFFFF, 32'h0080_0000, 1'b1, 32'h9, 32'h5);
    pair(4, 3'h0, 32'h4);
  endtask : t_windows
  task automatic t_mult();
    cfg(32'hFFFF, 32'h0005_0000, 1'b1, 32'h8, 32'h8);
    pair(4, 3'h0, 32'hC);
    cfg(32'hFFFF, 32'h0007_0000, 1'b1, 32'h8, 32'h8);
    pair(4, 3'h0, 32'h0);
  endtask : t_mult
  task automatic t_nbr();
    cfg(32'h0001_0004, 32'h1240_0001, 1'b1, 32'h8, 32'h8);
    pair(0, 3'h3, 32'h4);
    pair(0, 3'h1, 32'h0);
  endtask : t_nbr
  task automatic t_group();
    far_ch <= 4'h2;
    cfg(32'h0, 32'h8000_0000, 1'b1, 32'h8, 32'hC8);
    pair(0, 3'h4, 32'h4);
    wr(12'h004, 32'h0);
    wr(12'h004, 32'h1);
    @(posedge ref_clk);
    rdchk(12'h008, 32'h0, 1'b0);
    pair(0, 3'h0, 32'h0);
  endtask : t_group
  task automatic t_noreq();
    cfg(32'h4, 32'h0080_0000, 1'b0, 32'h8, 32'h8);
    pair(0, 3'h0, 32'h4);
  endtask : t_noreq
  task automatic t_probe();
    wr(12'h000, 32'h0082_8000);
    rdchk(12'h000, 32'h0082_8000, 1'b0);
    cfg(32'hFFFF, 32'h0080_0000, 1'b1, 32'h8, 32'h8);
    pa_cnt = 0;
    pd_cnt = 0;
    pw_cnt = 0;
    pv_cnt = 0;
    pair(4, 3'h0, 32'hC);
    `CHK(pa_cnt, 1)
    `CHK(pd_cnt, 6)
    `CHK(pw_cnt, 8)
    `CHK(pv_cnt != 0, 1'b1)
    wr(12'h000, 32'h0);
  endtask : t_probe
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    lft = 16'h0;
    far_fire = 3'h0;
    far_ch = 4'h0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t_regs();
    t_coinc();
    t_windows();
    t_mult();
    t_nbr();
    t_group();
    t_noreq();
    t_probe();
    stop_test();
  end
endmodule : ccv_top_tb
`default_nettype wire
